//--- tb/pdh_error_alarm_inserter_assertions.sv
`timescale 1ns/10ps
`include "pdh_map.svh"

module pdh_error_alarm_inserter_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rd_data_o,
  // payload and clocks
  input wire logic local_data_i,
  input wire logic rx_data_i,
  input wire logic ext_clk_i,
  input wire logic rec_clk_i,
  // line side
  input wire logic line_data_o,
  input wire logic line_en_o,
  input wire logic bit_strobe_o,
  input wire logic clk_detect_o,
  input wire logic irq_o
);
  logic [31:0] ctrl, mode, dest, mask;
  logic [4:0] calm;
  logic ok3, ok20;

  // settings mirrored from the write strobes
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl <= `RST_CTRL;
      mode <= `RST_MODE;
      dest <= `RST_DEST;
      mask <= 32'h0;
    end else if (wr_i) begin
      case (addr_i)
        `REG_CTRL: ctrl <= wr_data_i;
        `REG_MODE: mode <= wr_data_i;
        `REG_DEST: dest <= wr_data_i;
        `REG_MASK: mask <= wr_data_i;
        default: ;
      endcase
    end
  end

  // settle time: outputs lag a write by up to two cycles
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) calm <= 5'h0;
    else if (wr_i) calm <= 5'h0;
    else if (calm != 5'h1F) calm <= calm + 5'h1;
  end
  assign ok3 = calm >= 5'h3;
  assign ok20 = calm >= 5'h14;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // a clock-source write may restart the bit spacing
  sequence s_quiet;
    !(bit_strobe_o && ok3) [*8];
  endsequence
  sequence s_read(logic [3:0] a);
    $past(rd_i) && $past(addr_i) == a;
  endsequence

  property p_gap; bit_strobe_o && ok20 |=> s_quiet; endproperty
  a_gap: assert property (p_gap) else $error("bit strobes too close");
  property p_rd_idle; !$past(rd_i) || $past(addr_i[3]) |-> rd_data_o == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_ctrl; s_read(`REG_CTRL) |-> rd_data_o[5:0] == $past(ctrl[5:0]); endproperty
  a_ctrl: assert property (p_ctrl) else $error("control read back wrong");
  property p_dest;
    s_read(`REG_DEST) |-> (rd_data_o & 32'h001F_FF03) == ($past(dest) & 32'h001F_FF03);
  endproperty
  a_dest: assert property (p_dest) else $error("destination read back wrong");
  property p_off;
    ok3 && !ctrl[`CTRL_IFACE_ON] |-> !line_en_o && !bit_strobe_o && !line_data_o;
  endproperty
  a_off: assert property (p_off) else $error("line active while off");
  property p_on;
    ok3 && ctrl[`CTRL_IFACE_ON] && (mode[9:8] != 2'h2 || ctrl[`CTRL_STIM_FREQ]) |-> line_en_o;
  endproperty
  a_on: assert property (p_on) else $error("line idle while on");
  property p_los; ok3 && ctrl[0] && !ctrl[5] && mode[9:8] == 2'h2 |-> !line_en_o; endproperty
  a_los: assert property (p_los) else $error("loss alarm not held");
  property p_ais;
    ok20 && ctrl[0] && !ctrl[5] && mode[9:8] == 2'h1 && bit_strobe_o |-> line_data_o;
  endproperty
  a_ais: assert property (p_ais) else $error("all-ones alarm broken");
  property p_int_clk; ok3 && ctrl[3:2] == 2'h0 |-> clk_detect_o; endproperty
  a_int_clk: assert property (p_int_clk) else $error("internal clock not seen");
  property p_tick;
    line_en_o && $past(line_en_o) && $changed(line_data_o) |-> bit_strobe_o;
  endproperty
  a_tick: assert property (p_tick) else $error("line data moved off a bit");
  property p_irq; ok3 && mask[3:0] == 4'h0 |-> !irq_o; endproperty
  a_irq: assert property (p_irq) else $error("interrupt while all masked");
endmodule // pdh_error_alarm_inserter_checker

bind pdh_error_alarm_inserter pdh_error_alarm_inserter_checker i_pdh_error_alarm_inserter_checker (
  .clk_i, .nrst_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o, .local_data_i, .rx_data_i,
  .ext_clk_i, .rec_clk_i, .line_data_o, .line_en_o, .bit_strobe_o, .clk_detect_o, .irq_o
);

//--- tb/pdh_line_rx_model.sv
`timescale 1ns/10ps

module pdh_line_rx_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // line from the transmitter
  input wire logic line_i,
  input wire logic strobe_i,
  input wire logic en_i,
  // far side stream and clock
  input wire logic run_i,
  output logic rx_o,
  output logic rclk_o,
  // observations
  output logic [11:0] fword_o,
  output logic [7:0] ones_o,
  output int frames_o
);
  logic [7:0] pos, acc;
  logic [3:0] div;

  // all-ones received stream, so local bits stand out in the payload
  assign rx_o = 1'b1;
  // recovered clock stands still when the line is not running
  assign rclk_o = div[3];

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) div <= 4'h0;
    else if (run_i) div <= div + 4'h1;
  end

  // bits counted by strobe, not by time, so any rate is taken
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pos <= 8'h0;
      acc <= 8'h0;
      fword_o <= 12'h0;
      ones_o <= 8'h0;
      frames_o <= 0;
    end else if (strobe_i && en_i) begin
      if (pos == 8'h0) fword_o <= {fword_o[10:0], line_i};
      else acc <= acc + {7'h0, line_i};
      if (pos == 8'hC0) begin
        pos <= 8'h0;
        ones_o <= acc + {7'h0, line_i};
        acc <= 8'h0;
        frames_o <= frames_o + 1;
      end else begin
        pos <= pos + 8'h1;
      end
    end
  end
endmodule // pdh_line_rx_model

//--- tb/test_pdh_error_alarm_inserter.sv
`timescale 1ns/10ps
`include "pdh_map.svh"

module test_pdh_error_alarm_inserter;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wr_data_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic local_data_i = 1'b0;
  logic ext_clk_i = 1'b0;
  logic fclk_run = 1'b1;
  logic [3:0] ext_div = 4'h0;
  logic [31:0] rd_data_o, d;
  logic rx_data_i, rec_clk_i, line_data_o, line_en_o, bit_strobe_o, clk_detect_o, irq_o;
  logic [11:0] fword;
  logic [7:0] pones;
  int frames, n;
  int errors = 0;
  int num_checks = 0;

  always #20 clk_i = ~clk_i;

  // external clock, 16 cycles a bit, frozen while fclk_run is low
  always @(posedge clk_i) begin
    if (fclk_run) begin
      ext_div <= ext_div + 4'h1;
      ext_clk_i <= ext_div[3];
    end
  end

  pdh_error_alarm_inserter i_pdh_error_alarm_inserter (
    .clk_i, .nrst_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o, .local_data_i,
    .rx_data_i, .ext_clk_i, .rec_clk_i, .line_data_o, .line_en_o, .bit_strobe_o,
    .clk_detect_o, .irq_o
  );

  pdh_line_rx_model i_pdh_line_rx_model (
    .clk_i, .nrst_i, .line_i(line_data_o), .strobe_i(bit_strobe_o), .en_i(line_en_o),
    .run_i(fclk_run), .rx_o(rx_data_i), .rclk_o(rec_clk_i), .fword_o(fword),
    .ones_o(pones), .frames_o(frames)
  );

  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wr_data_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    v = rd_data_o;
  endtask

  task wait_frames(input int k);
    int target;
    target = frames + k;
    for (int i = 0; i < 4000 * k && frames < target; i++) @(negedge clk_i);
  endtask

  // strobes counted; with any low only those carrying a zero
  task count(input int cyc, input logic any);
    n = 0;
    repeat (cyc) begin
      @(negedge clk_i);
      n += int'(bit_strobe_o && (any || !line_data_o));
    end
  endtask

  task t_regs;
    logic [3:0] a[6] = '{`REG_CTRL, `REG_MODE, `REG_DEST, `REG_OFFSET, `REG_MASK, 4'hF};
    logic [31:0] e[6] = '{`RST_CTRL, `RST_MODE, `RST_DEST, 32'h0, 32'h0, 32'h0};
    foreach (a[i]) begin
      rd(a[i], d);
      check(d, e[i]);
    end
    wr(4'hB, 32'hFFFF_FFFF);
    rd(4'hB, d);
    check(d, 32'h0);
    wr(`REG_OFFSET, 32'h0000_FF38);
    rd(`REG_OFFSET, d);
    check(d, 32'hFFFF_FF38);
    wr(`REG_OFFSET, 32'h0);
  endtask

  task t_frame;
    logic [23:0] dbl;
    logic hit;
    dbl = {`MF_PATTERN, `MF_PATTERN};
    hit = 1'b0;
    wr(`REG_CTRL, 32'h0000_0003);
    wr(`REG_DEST, 32'h0018_0100);
    wait_frames(13);
    for (int i = 0; i < 12; i++) hit |= (fword === dbl[i +: 12]);
    check({31'h0, hit}, 32'h1);
    check({24'h0, pones}, 32'h0000_00B8);
    wr(`REG_CTRL, 32'h0000_0001);
    wait_frames(2);
    check({24'h0, pones}, 32'h0);
  endtask

  task t_rate;
    logic [31:0] c[3] = '{32'h1, 32'h21, 32'h31};
    logic [15:0] p[3] = '{16'h4E20, 16'h4E20, 16'h4E20};
    logic [15:0] q[3] = '{16'h0, 16'h4E20, 16'h0};
    longint x;
    for (int i = 0; i < 3; i++) begin
      wr(`REG_CTRL, c[i]);
      wr(`REG_OFFSET, {16'h0, p[i]});
      repeat (20) @(negedge clk_i);
      count(3000, 1'b1);
      x = (longint'(3000) * (`NCO_BASE + q[i] * `NCO_PER_PPM)) >> 32;
      check({31'h0, n >= x - 1 && n <= x + 1}, 32'h1);
    end
    wr(`REG_CTRL, 32'h1);
    wr(`REG_OFFSET, 32'h0);
  endtask

  task t_irq;
    wr(`REG_MASK, 32'h1);
    rd(`REG_STATUS, d);
    wr(`REG_INSERT, 32'h0);
    repeat (3) @(negedge clk_i);
    check(irq_o, 32'h1);
    rd(`REG_STATUS, d);
    check(d[`ST_INSERT], 32'h1);
    repeat (2) @(negedge clk_i);
    check(irq_o, 32'h0);
    wr(`REG_MASK, 32'h0);
    wr(`REG_INSERT, 32'h0);
    repeat (3) @(negedge clk_i);
    check(irq_o, 32'h0);
    rd(`REG_STATUS, d);
    check(d[`ST_INSERT], 32'h1);
    rd(`REG_STATUS, d);
    check(d[`ST_INSERT], 32'h0);
  endtask

  // early in the run: frame count well below 255, not frame 0 of the second
  task t_err;
    logic [31:0] md[5] = '{32'h32, 32'h32, 32'h33, 32'h34, 32'h30};
    logic [31:0] ds[5] = '{32'h200, 32'hFF00, 32'h200, 32'h200, 32'h200};
    logic ex[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    wr(`REG_DEST, 32'h0000_0200);
    wr(`REG_MODE, 32'h0000_0031);
    wr(`REG_INSERT, 32'h0);
    rd(`REG_INFO, d);
    check({24'h0, d[15:8]}, 32'h2);
    repeat (10000) @(negedge clk_i);
    rd(`REG_INFO, d);
    check({16'h0, d[15:0] & 16'hFF04}, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(`REG_DEST, ds[i]);
      wr(`REG_MODE, md[i]);
      wr(`REG_INSERT, 32'h0);
      repeat (3300) @(negedge clk_i);
      rd(`REG_INFO, d);
      check({23'h0, d[15:8], d[2]}, {31'h0, ex[i]});
    end
  endtask

  task t_clk;
    for (int s = 1; s < 3; s++) begin
      wr(`REG_CTRL, {28'h0, s[1:0], 2'b01});
      repeat (200) @(negedge clk_i);
      check(clk_detect_o, 32'h1);
      count(160, 1'b1);
      check({31'h0, n >= 9 && n <= 11}, 32'h1);
      @(posedge clk_i);
      fclk_run <= 1'b0;
      repeat (100) @(negedge clk_i);
      check(clk_detect_o, 32'h0);
      rd(`REG_STATUS, d);
      check(d[`ST_CLK_LOST], 32'h1);
      @(posedge clk_i);
      fclk_run <= 1'b1;
    end
    wr(`REG_CTRL, 32'h1);
  endtask

  task t_off;
    wr(`REG_CTRL, 32'h0);
    repeat (5) @(negedge clk_i);
    check({line_en_o, line_data_o}, 32'h0);
    wr(`REG_CTRL, 32'h1);
    repeat (5) @(negedge clk_i);
    check(line_en_o, 32'h1);
    wr(`REG_MODE, 32'h230);
    repeat (5) @(negedge clk_i);
    check(line_en_o, 32'h0);
    wr(`REG_CTRL, 32'h21);
    repeat (5) @(negedge clk_i);
    check(line_en_o, 32'h1);
    wr(`REG_CTRL, 32'h1);
    wr(`REG_MODE, 32'h130);
    repeat (40) @(negedge clk_i);
    count(200, 1'b0);
    check(n, 32'h0);
    wr(`REG_MODE, 32'h30);
  endtask

  task stop_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_regs();
    t_frame();
    t_rate();
    t_irq();
    t_err();
    t_clk();
    t_off();
    stop_test();
  end

  // a passing run takes about 85000 cycles
  initial begin
    #3800000;
    errors++;
    stop_test();
  end
endmodule // test_pdh_error_alarm_inserter

//--- verilog/pdh_error_alarm_inserter.sv
`timescale 1ns/10ps
`include "pdh_map.svh"
// Notes on behaviour
// - stimulus is alarm/error or frequency offset
// - selected alarm held until selection changes
// - no-error setting inserts nothing
// - manual trigger injects configured count, then stops
// - burst corrupts length frames per 10^n
// - trigger only reports status in automatic modes
// - errored second: error every second
// - severely errored: at most 30% per second
// - destination and burst length are programmable
// - offset only without higher layer above
// - rate scaled by one plus ppm
// - nominal 1.544 Mbit/s, 125 ppm tolerance
// - 193-bit frame: framing bit, 24 channels
// - multiframe alignment carried in the framing bits
// - drop-and-insert selects received or local payload
// - clock from internal, external or recovered
// - indicate detection of selected foreign clock

module pdh_error_alarm_inserter (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rd_data_o,
  // payload sources
  input wire logic local_data_i,
  input wire logic rx_data_i,
  // foreign clocks
  input wire logic ext_clk_i,
  input wire logic rec_clk_i,
  // line side
  output logic line_data_o,
  output logic line_en_o,
  output logic bit_strobe_o,
  output logic clk_detect_o,
  output logic irq_o
);
  localparam int CLK_TIMEOUT = `CLK_TIMEOUT_NS / `CLK_PERIOD_NS;
  localparam int FRAMES_PER_SEC = 1000000 / `FRAME_US;
  localparam int SES_LIMIT = FRAMES_PER_SEC * `SES_PCT / 100;

  logic [31:0] ctrl;
  logic [31:0] mode;
  logic [31:0] dest;
  logic signed [15:0] offset_ppm;
  logic [`ST_W-1:0] status;
  logic [`ST_W-1:0] mask;

  logic [2:0] ext_sync;
  logic [2:0] rec_sync;
  logic [1:0] rx_sync;
  logic [31:0] phase;
  logic signed [32:0] next_step;
  logic [32:0] phase_sum;
  logic bit_tick;
  logic [6:0] idle_cnt;
  logic clk_seen;
  logic [7:0] bit_idx;
  logic [12:0] sec_frame;
  logic frame_start;
  logic sec_start;
  logic win_start;
  logic [3:0] mf_idx;
  logic [7:0] manual_left;
  logic [7:0] win_frame;
  logic corrupt_frame;
  logic next_bit;
  logic [4:0] chan;

  pdh_pkg::err_mode_t err_mode;
  pdh_pkg::alarm_t alarm;
  pdh_pkg::clk_src_t clk_src;
  pdh_pkg::dest_t dest_sel;
  logic [7:0] burst_len;
  logic [4:0] insert_slot;
  logic stim_freq;
  logic insert_wr;

  // 10^n frames for the burst window, exponent clamped to the legal span
  function automatic logic [23:0] burst_window(input logic [2:0] exp_n);
    logic [23:0] w;
    w = 24'h00_03E8;
    unique case (exp_n)
      3'h4: w = 24'h00_2710;
      3'h5: w = 24'h01_86A0;
      3'h6: w = 24'h0F_4240;
      3'h7: w = 24'h98_9680;
      default: w = 24'h00_03E8;
    endcase
    return w;
  endfunction

  function automatic logic is_write(input logic [3:0] a, input logic [3:0] r, input logic w);
    return w && (a == r);
  endfunction

  assign err_mode = pdh_pkg::err_mode_t'(mode[`MODE_ERR_HI:`MODE_ERR_LO]);
  assign alarm = pdh_pkg::alarm_t'(mode[`MODE_ALM_HI:`MODE_ALM_LO]);
  assign clk_src = pdh_pkg::clk_src_t'(ctrl[`CTRL_CLK_HI:`CTRL_CLK_LO]);
  assign dest_sel = pdh_pkg::dest_t'(dest[`DEST_SEL_HI:`DEST_SEL_LO]);
  assign burst_len = dest[`DEST_LEN_HI:`DEST_LEN_LO];
  assign insert_slot = dest[`DEST_SLOT_HI:`DEST_SLOT_LO];
  assign stim_freq = ctrl[`CTRL_STIM_FREQ];
  assign insert_wr = is_write(addr_i, `REG_INSERT, wr_i);

  // register writes
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl <= `RST_CTRL;
      mode <= `RST_MODE;
      dest <= `RST_DEST;
      offset_ppm <= `RST_OFFSET;
      mask <= '0;
    end else begin
      if (is_write(addr_i, `REG_CTRL, wr_i)) begin
        ctrl <= wr_data_i;
      end
      if (is_write(addr_i, `REG_MODE, wr_i)) begin
        mode <= wr_data_i;
      end
      if (is_write(addr_i, `REG_DEST, wr_i)) begin
        dest <= wr_data_i;
      end
      if (is_write(addr_i, `REG_OFFSET, wr_i)) begin
        offset_ppm <= wr_data_i[15:0];
      end
      if (is_write(addr_i, `REG_MASK, wr_i)) begin
        mask <= wr_data_i[`ST_W-1:0];
      end
    end
  end

  // register reads, data one cycle later
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_data_o <= 32'h0000_0000;
    end else if (rd_i) begin
      unique case (addr_i)
        `REG_CTRL: rd_data_o <= ctrl;
        `REG_MODE: rd_data_o <= mode;
        `REG_DEST: rd_data_o <= dest;
        `REG_OFFSET: rd_data_o <= {{16{offset_ppm[15]}}, offset_ppm};
        `REG_STATUS: rd_data_o <= {28'h000_0000, status};
        `REG_MASK: rd_data_o <= {28'h000_0000, mask};
        `REG_INFO: rd_data_o <= {16'h0000, manual_left, 5'h00, corrupt_frame,
                                 clk_seen, line_en_o};
        default: rd_data_o <= 32'h0000_0000;
      endcase
    end else begin
      rd_data_o <= 32'h0000_0000;
    end
  end

  // sticky events; a set in the clearing read cycle survives
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status <= '0;
    end else begin
      status <= (rd_i && addr_i == `REG_STATUS ? '0 : status)
        | {sec_start, win_start && err_mode == pdh_pkg::ERR_BURST,
           !clk_seen && clk_detect_o && clk_src != pdh_pkg::CLK_INTERNAL, insert_wr};
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status & mask);
    end
  end

  // foreign clocks and received data pass two flops first
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_sync <= 3'h0;
      rec_sync <= 3'h0;
      rx_sync <= 2'h0;
    end else begin
      ext_sync <= {ext_sync[1:0], ext_clk_i};
      rec_sync <= {rec_sync[1:0], rec_clk_i};
      rx_sync <= {rx_sync[0], rx_data_i};
    end
  end

  // offset only for frequency stimulus with no upper layer present
  always_comb begin
    next_step = 33'(`NCO_BASE);
    if (stim_freq && !ctrl[`CTRL_UPPER_LAYER]) begin
      next_step = 33'(`NCO_BASE) + 33'(offset_ppm) * 33'(`NCO_PER_PPM);
    end
  end
  assign phase_sum = {1'b0, phase} + {1'b0, next_step[31:0]};

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase <= 32'h0000_0000;
    end else begin
      phase <= phase_sum[31:0];
    end
  end

  // one tick per line bit from the chosen source
  always_comb begin
    unique case (clk_src)
      pdh_pkg::CLK_EXTERNAL: bit_tick = ext_sync[1] && !ext_sync[2];
      pdh_pkg::CLK_RECOVERED: bit_tick = rec_sync[1] && !rec_sync[2];
      default: bit_tick = phase_sum[32];
    endcase
  end

  // foreign clock counts as lost after a quiet spell
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      idle_cnt <= 7'h00;
      clk_seen <= 1'b0;
    end else if (clk_src == pdh_pkg::CLK_INTERNAL) begin
      idle_cnt <= 7'h00;
      clk_seen <= 1'b1;
    end else if (bit_tick) begin
      idle_cnt <= 7'h00;
      clk_seen <= 1'b1;
    end else if (idle_cnt == 7'(CLK_TIMEOUT - 1)) begin
      clk_seen <= 1'b0;
    end else begin
      idle_cnt <= idle_cnt + 7'h01;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clk_detect_o <= 1'b0;
    end else begin
      clk_detect_o <= clk_seen;
    end
  end

  pdh_frame_timer u_timer (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .bit_tick_i(bit_tick),
    .window_i(burst_window(mode[`MODE_EXP_HI:`MODE_EXP_LO])),
    .bit_idx_o(bit_idx),
    .sec_frame_o(sec_frame),
    .frame_start_o(frame_start),
    .sec_start_o(sec_start),
    .win_start_o(win_start)
  );

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mf_idx <= 4'h0;
    end else if (frame_start) begin
      mf_idx <= (mf_idx == 4'(`MF_LEN - 1)) ? 4'h0 : mf_idx + 4'h1;
    end
  end

  // manual: a trigger arms the count; automatic modes ignore it
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      manual_left <= 8'h00;
    end else if (err_mode != pdh_pkg::ERR_MANUAL || stim_freq) begin
      manual_left <= 8'h00;
    end else if (insert_wr) begin
      manual_left <= burst_len;
    end else if (frame_start && manual_left != 8'h00) begin
      manual_left <= manual_left - 8'h01;
    end
  end

  // frame position in the window, saturating; entering burst mode
  // mid-window corrupts only frames whose position is still below burst_len
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      win_frame <= 8'h00;
    end else if (win_start) begin
      win_frame <= 8'h01;
    end else if (frame_start && win_frame != 8'hFF) begin
      win_frame <= win_frame + 8'h01;
    end
  end

  // per-frame corruption decision, taken at the framing bit
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      corrupt_frame <= 1'b0;
    end else if (frame_start) begin
      if (stim_freq) begin
        corrupt_frame <= 1'b0;
      end else begin
        unique case (err_mode)
          pdh_pkg::ERR_MANUAL: corrupt_frame <= manual_left != 8'h00;
          pdh_pkg::ERR_BURST: corrupt_frame <= win_start ? burst_len != 8'h00
                                                          : win_frame < burst_len;
          pdh_pkg::ERR_ES: corrupt_frame <= sec_start;
          pdh_pkg::ERR_SES: corrupt_frame <= sec_frame < 13'(SES_LIMIT);
          default: corrupt_frame <= 1'b0;
        endcase
      end
    end
  end

  assign chan = 5'((bit_idx - 8'h01) >> 3);

  // framing bit carries the multiframe word, payload per drop-and-insert
  always_comb begin
    next_bit = local_data_i;
    if (bit_idx == 8'h00) begin
      next_bit = 1'(`MF_PATTERN >> (`MF_LEN - 1 - int'(mf_idx)));
    end else if (ctrl[`CTRL_DROP_INSERT] && (chan + 5'h01) != insert_slot) begin
      next_bit = rx_sync[1];
    end
    if (corrupt_frame && !stim_freq) begin
      unique case (dest_sel)
        pdh_pkg::DST_FRAMING: next_bit = next_bit ^ (bit_idx == 8'h00);
        pdh_pkg::DST_BIT: next_bit = next_bit ^ (bit_idx == 8'h01);
        default: next_bit = next_bit ^ (bit_idx != 8'h00);
      endcase
    end
    if (!stim_freq) begin
      unique case (alarm)
        pdh_pkg::ALM_AIS: next_bit = 1'b1;
        pdh_pkg::ALM_OOF: next_bit = next_bit ^ (bit_idx == 8'h00);
        default: next_bit = next_bit;
      endcase
    end
  end

  // line bit is refreshed only on a tick while the interface is on, held low while off; a lost clock freezes the line
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      line_data_o <= 1'b0;
      bit_strobe_o <= 1'b0;
      line_en_o <= 1'b0;
    end else begin
      bit_strobe_o <= bit_tick && ctrl[`CTRL_IFACE_ON];
      line_en_o <= ctrl[`CTRL_IFACE_ON]
        && !(alarm == pdh_pkg::ALM_LOS && !stim_freq);
      if (!ctrl[`CTRL_IFACE_ON]) begin
        line_data_o <= 1'b0;
      end else if (bit_tick) begin
        line_data_o <= next_bit;
      end
    end
  end
endmodule // pdh_error_alarm_inserter

//--- verilog/pdh_frame_timer.sv
`timescale 1ns/10ps
`include "pdh_map.svh"

module pdh_frame_timer (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // timing
  input wire logic bit_tick_i,
  input wire logic [23:0] window_i,
  // positions
  output logic [7:0] bit_idx_o,
  output logic [12:0] sec_frame_o,
  output logic frame_start_o,
  output logic sec_start_o,
  output logic win_start_o
);
  localparam int FRAMES_PER_SEC = 1000000 / `FRAME_US;
  logic [23:0] win_cnt;

  assign frame_start_o = bit_tick_i && (bit_idx_o == 8'h00);
  assign sec_start_o = frame_start_o && (sec_frame_o == 13'h0000);
  assign win_start_o = frame_start_o && (win_cnt == 24'h00_0000);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bit_idx_o <= 8'h00;
    end else if (bit_tick_i) begin
      bit_idx_o <= (bit_idx_o == 8'(`FRAME_BITS - 1)) ? 8'h00 : bit_idx_o + 8'h01;
    end
  end

  // seconds counted in frames, not wall time, so offsets stretch them
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sec_frame_o <= 13'h0000;
    end else if (frame_start_o) begin
      sec_frame_o <= (sec_frame_o == 13'(FRAMES_PER_SEC - 1)) ? 13'h0000 : sec_frame_o + 13'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      win_cnt <= 24'h00_0000;
    end else if (frame_start_o) begin
      win_cnt <= (win_cnt >= window_i - 24'h00_0001) ? 24'h00_0000 : win_cnt + 24'h00_0001;
    end
  end
endmodule // pdh_frame_timer

//--- verilog/pdh_map.svh
`ifndef PDH_MAP_SVH
`define PDH_MAP_SVH

// register indices on the plain register port
`define REG_CTRL 4'h0
`define REG_MODE 4'h1
`define REG_DEST 4'h2
`define REG_OFFSET 4'h3
`define REG_INSERT 4'h4
`define REG_STATUS 4'h5
`define REG_MASK 4'h6
`define REG_INFO 4'h7

// control register fields
`define CTRL_IFACE_ON 0
`define CTRL_DROP_INSERT 1
`define CTRL_CLK_LO 2
`define CTRL_CLK_HI 3
`define CTRL_UPPER_LAYER 4
`define CTRL_STIM_FREQ 5

// mode register fields
`define MODE_ERR_LO 0
`define MODE_ERR_HI 2
`define MODE_EXP_LO 4
`define MODE_EXP_HI 6
`define MODE_ALM_LO 8
`define MODE_ALM_HI 9

// destination register fields
`define DEST_SEL_LO 0
`define DEST_SEL_HI 1
`define DEST_LEN_LO 8
`define DEST_LEN_HI 15
`define DEST_SLOT_LO 16
`define DEST_SLOT_HI 20

// status and mask bit positions
`define ST_INSERT 0
`define ST_CLK_LOST 1
`define ST_BURST 2
`define ST_SECOND 3
`define ST_W 4

// reset values
`define RST_CTRL 32'h0000_0001
`define RST_MODE 32'h0000_0030
`define RST_DEST 32'h0000_0100
`define RST_OFFSET 16'h0000

// frame timing
`define FRAME_BITS 193
`define CHAN_BITS 8
`define FRAME_US 125
`define SES_PCT 30
`define BURST_EXP_MIN 3
`define BURST_EXP_MAX 7
`define MF_PATTERN 12'h8DC
`define MF_LEN 12

// rate generator: 1.544 Mbit/s from 25 MHz, 32-bit phase step
`define NCO_BASE 32'h0FCF_8F5C
`define NCO_PER_PPM 32'h0000_0109

// clock presence
`define CLK_TIMEOUT_NS 2000
`define CLK_PERIOD_NS 40

`endif

//--- verilog/pdh_pkg.sv
package pdh_pkg;
  typedef enum logic [2:0] {ERR_NONE, ERR_MANUAL, ERR_BURST, ERR_ES, ERR_SES} err_mode_t;
  typedef enum logic [1:0] {ALM_NONE, ALM_AIS, ALM_LOS, ALM_OOF} alarm_t;
  typedef enum logic [1:0] {CLK_INTERNAL, CLK_EXTERNAL, CLK_RECOVERED, CLK_SPARE} clk_src_t;
  typedef enum logic [1:0] {DST_FRAMING, DST_BIT, DST_PAYLOAD, DST_SPARE} dest_t;
endpackage
